// File: lhcf_regs.svh
// constants for the limp-home clock fallback controller
`ifndef LHCF_REGS_SVH
`define LHCF_REGS_SVH
`define LHCF_CNT_W       13
`define LHCF_MID_COUNT   13'h1000
`define LHCF_STOP_DLY    13'h1000
`define LHCF_CHECK_EVERY 14'h2000
`endif

// File: lhcf_pkg.sv
// types for the limp-home clock fallback controller
package lhcf_pkg;
    typedef enum logic [2:0] {
        LHCF_POR,
        LHCF_IRST,
        LHCF_RUN,
        LHCF_STOP,
        LHCF_STOP_WAIT,
        LHCF_CMRST
    } lhcf_state_e;
endpackage

// File: lhcf_fallback.sv
// limp-home clock fallback and stop recovery controller
`timescale 1ns/100ps
`include "lhcf_regs.svh"
module lhcf_fallback (
    input  wire logic sys_clk_i,            // timer/watchdog clock domain
    input  wire logic reset_i,              // any reset, sync active high
    input  wire logic clk_en_i,             // freezes all state when low
    input  wire logic por_i,                // power-on pulse, high while active
    input  wire logic ext_clk_present_i,    // clock monitor presence, async
    input  wire logic pll_supply_i,         // high when pll supply at core level
    input  wire logic special_mode_i,       // high in special operating modes
    input  wire logic clock_monitor_on_i,   // software monitor enable
    input  wire logic forced_clock_monitor_on_i, // software forced monitor enable
    input  wire logic fallback_disable_i,   // software fallback disable
    input  wire logic fallback_disable_we_i, // write strobe for disable bit
    input  wire logic clock_monitor_on_we_i, // write strobe for monitor bit
    input  wire logic bus_clock_from_pll_i, // software bus-from-pll select
    input  wire logic module_clock_select_i, // software module clock select
    input  wire logic auto_bw_i,            // automatic bandwidth control
    input  wire logic fallback_irq_enable_i, // change interrupt enable
    input  wire logic change_flag_clr_i,    // software clear of change flag
    input  wire logic stop_exit_delay_i,    // stop exit delay bit
    input  wire logic stop_req_i,           // stop instruction executed
    input  wire logic ext_reset_i,          // wake: external reset
    input  wire logic irq_pin_i,            // wake: maskable irq pin
    input  wire logic nonmaskable_irq_pin_i, // wake: nonmaskable irq pin
    input  wire logic key_wake_j_i,         // wake: port j key
    input  wire logic key_wake_h_i,         // wake: port h key
    input  wire logic can_wake_i,           // wake: can controller
    output logic      fallback_active_flag_o, // in fallback operation
    output logic      fallback_change_flag_o, // sticky change flag
    output logic      fallback_irq_o,       // change interrupt request
    output logic      pll_on_a_o,           // pll on control
    output logic      bus_clock_from_pll_o, // effective bus clock from pll
    output logic      module_clock_select_o, // effective module clock select
    output logic      base_system_clock_from_vco_min_o, // system clock from minimum vco
    output logic      modclk_from_pll_o,    // timer_watchdog_clock, debug, periph from pll source
    output logic      monitor_enable_o,     // effective clock monitor enable
    output logic      clock_monitor_on_o,   // stored monitor enable bit
    output logic      fallback_disable_o,   // stored fallback disable bit
    output logic      internal_reset_o,     // internal reset to the chip
    output logic      monitor_reset_o,      // clock monitor reset request
    output logic      stopped_o,            // chip held in stop
    output logic      pll_relock_o          // pll should relock after exit
);
    // state and stored values
    lhcf_pkg::lhcf_state_e state_q, state_d;
    logic [`LHCF_CNT_W-1:0] cnt_q;          // 13-stage counter
    logic       pres_s1_q, pres_s2_q;       // presence synchroniser
    logic       lh_q;                       // fallback active
    logic       chg_q;                      // change flag
    logic       cme_q, fallback_disable_q;             // stored control bits
    logic       bus_clock_from_pll_save_q, mcs_save_q;    // pre-loss selects
    logic       auto_save_q;                // pre-loss auto bit
    logic       relock_q;                   // relock request
    logic       stop_dly_q;                 // delay bit at stop entry

    // decoding
    wire mon_sw   = cme_q | forced_clock_monitor_on_i;
    wire mon_en   = lh_q | mon_sw;
    wire lh_allow = pll_supply_i & ~fallback_disable_q;
    wire mid_hit  = (cnt_q == `LHCF_MID_COUNT);
    wire present  = pres_s2_q;
    wire lost     = mon_en & ~present;
    wire wake     = ext_reset_i | irq_pin_i | nonmaskable_irq_pin_i |
                    key_wake_j_i | key_wake_h_i | can_wake_i;
    wire in_run   = (state_q == lhcf_pkg::LHCF_RUN);
    wire go_lh    = in_run & ~lh_q & lost & lh_allow;
    wire go_rst   = in_run & lost & ~lh_allow & mon_sw;
    wire chk_exit = in_run & lh_q & mid_hit & present;
    wire st_wait  = (state_q == lhcf_pkg::LHCF_STOP_WAIT);
    wire wait_end = st_wait & (~stop_dly_q | mid_hit);
    wire lh_set   = go_lh |
                    ((state_q == lhcf_pkg::LHCF_IRST) & mid_hit & ~present
                     & pll_supply_i & ~special_mode_i) |
                    (wait_end & ~present & lh_allow);
    wire lh_clr   = chk_exit | (wait_end & present);

    // next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            lhcf_pkg::LHCF_POR: begin
                if (!por_i) state_d = lhcf_pkg::LHCF_IRST;
            end
            lhcf_pkg::LHCF_IRST: begin
                // static without a clock when pll supply grounded
                if (mid_hit && (present || (pll_supply_i && !special_mode_i)))
                    state_d = lhcf_pkg::LHCF_RUN;
            end
            lhcf_pkg::LHCF_RUN: begin
                if (go_rst) state_d = lhcf_pkg::LHCF_CMRST;
                else if (stop_req_i && (lh_allow || !mon_sw))
                    state_d = lhcf_pkg::LHCF_STOP;
                else if (stop_req_i) state_d = lhcf_pkg::LHCF_CMRST;
            end
            lhcf_pkg::LHCF_STOP: begin
                if (wake) state_d = lhcf_pkg::LHCF_STOP_WAIT;
            end
            lhcf_pkg::LHCF_STOP_WAIT: begin
                if (wait_end) state_d = lhcf_pkg::LHCF_RUN;
            end
            lhcf_pkg::LHCF_CMRST: begin
                // only external clock activity leaves this reset
                if (present) state_d = lhcf_pkg::LHCF_IRST;
            end
            default: state_d = lhcf_pkg::LHCF_POR;
        endcase
    end

    // state register and counter
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_q <= lhcf_pkg::LHCF_POR;
            cnt_q   <= '0;
        end else if (clk_en_i) begin
            state_q <= state_d;
            if (state_d != state_q) cnt_q <= '0;
            else cnt_q <= cnt_q + 13'h0001;
        end
    end

    // presence synchroniser
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pres_s1_q <= 1'b0;
            pres_s2_q <= 1'b0;
        end else if (clk_en_i) begin
            pres_s1_q <= ext_clk_present_i;
            pres_s2_q <= pres_s1_q;
        end
    end

    // control bits, set by every reset
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cme_q   <= 1'b1;
            fallback_disable_q <= 1'b0;
        end else if (clk_en_i) begin
            if (state_q == lhcf_pkg::LHCF_CMRST) begin
                // the monitor reset is a reset as well, so it restores both bits
                cme_q   <= 1'b1;
                fallback_disable_q <= 1'b0;
            end else begin
                if (clock_monitor_on_we_i) cme_q <= clock_monitor_on_i;
                if (fallback_disable_we_i) fallback_disable_q <= fallback_disable_i;
            end
        end
    end

    // fallback flag, change flag and saved selects
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            lh_q        <= 1'b0;
            chg_q       <= 1'b0;
            bus_clock_from_pll_save_q <= 1'b0;
            mcs_save_q  <= 1'b0;
            auto_save_q <= 1'b0;
            relock_q    <= 1'b0;
            stop_dly_q  <= 1'b0;
        end else if (clk_en_i) begin
            if (lh_set) lh_q <= 1'b1;
            else if (lh_clr) lh_q <= 1'b0;
            // set wins over a clear in the same cycle
            if ((lh_set & ~lh_q) | (lh_clr & lh_q)) chg_q <= 1'b1;
            else if (change_flag_clr_i) chg_q <= 1'b0;
            if (lh_set & ~lh_q) begin
                bus_clock_from_pll_save_q <= bus_clock_from_pll_i;
                mcs_save_q  <= module_clock_select_i;
                auto_save_q <= auto_bw_i;
            end
            // software may drop the pll select while in fallback
            if (lh_q) bus_clock_from_pll_save_q <= bus_clock_from_pll_i;
            relock_q <= lh_clr & lh_q & auto_save_q & bus_clock_from_pll_save_q;
            if (stop_req_i && in_run) stop_dly_q <= stop_exit_delay_i;
        end
    end

    // registered outputs
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            fallback_active_flag_o <= 1'b0;
            fallback_change_flag_o <= 1'b0;
            fallback_irq_o         <= 1'b0;
            pll_on_a_o             <= 1'b1;
            bus_clock_from_pll_o   <= 1'b0;
            module_clock_select_o  <= 1'b0;
            base_system_clock_from_vco_min_o  <= 1'b0;
            modclk_from_pll_o      <= 1'b0;
            monitor_enable_o       <= 1'b1;
            clock_monitor_on_o     <= 1'b1;
            fallback_disable_o     <= 1'b0;
            internal_reset_o       <= 1'b1;
            monitor_reset_o        <= 1'b0;
            stopped_o              <= 1'b0;
            pll_relock_o           <= 1'b0;
        end else if (clk_en_i) begin
            fallback_active_flag_o <= lh_q;
            fallback_change_flag_o <= chg_q;
            fallback_irq_o         <= chg_q & fallback_irq_enable_i;
            pll_on_a_o             <= lh_q | pll_supply_i;
            bus_clock_from_pll_o   <= lh_q | (relock_q | bus_clock_from_pll_save_q)
                                      & bus_clock_from_pll_i;
            module_clock_select_o  <= lh_q ? 1'b0 : module_clock_select_i;
            base_system_clock_from_vco_min_o  <= lh_q;
            modclk_from_pll_o      <= lh_q;
            monitor_enable_o       <= mon_en;
            clock_monitor_on_o     <= cme_q;
            fallback_disable_o     <= fallback_disable_q;
            internal_reset_o       <= (state_q == lhcf_pkg::LHCF_POR) |
                                      (state_q == lhcf_pkg::LHCF_IRST) |
                                      (state_q == lhcf_pkg::LHCF_CMRST);
            monitor_reset_o        <= (state_q == lhcf_pkg::LHCF_CMRST);
            stopped_o              <= (state_q == lhcf_pkg::LHCF_STOP) | st_wait;
            pll_relock_o           <= relock_q;
        end
    end

    // checks
    AST_INTRST_END: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        clk_en_i && state_q == lhcf_pkg::LHCF_IRST && mid_hit && present
        |=> state_q == lhcf_pkg::LHCF_RUN)
        else $error("internal reset did not end at mid count");
    AST_LH_ENTER: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        clk_en_i && go_lh |=> lh_q)
        else $error("fallback not entered on clock loss");
    AST_CM_RESET: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        clk_en_i && go_rst |=> state_q == lhcf_pkg::LHCF_CMRST && !lh_q)
        else $error("monitor reset not taken");
    AST_FORCE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        clk_en_i && lh_q |=> bus_clock_from_pll_o && pll_on_a_o && !module_clock_select_o)
        else $error("fallback selects not forced");
    AST_FLAG: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        clk_en_i |=> fallback_active_flag_o == $past(lh_q))
        else $error("active flag mismatch");
    AST_CHANGE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        clk_en_i && $changed(lh_q) |-> chg_q)
        else $error("change flag not set on flag change");
    AST_MON_ON: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        lh_q |-> mon_en)
        else $error("monitor off in fallback");
    AST_CHECK_ONLY_MID: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        clk_en_i && in_run && lh_q && !mid_hit |=> lh_q)
        else $error("fallback left away from check point");
    AST_EXIT: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        clk_en_i && chk_exit |=> !lh_q && chg_q)
        else $error("fallback not left on clock return");
    AST_STOP_DLY: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        clk_en_i && st_wait && stop_dly_q && !mid_hit |=> st_wait)
        else $error("stop delay ended early");
    AST_MRST_BITS: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        clk_en_i && state_q == lhcf_pkg::LHCF_CMRST |=> cme_q && !fallback_disable_q)
        else $error("monitor reset kept control bits");
endmodule

// File: lhcf_xtal_model.sv
// behavioural crystal or square-wave source that feeds the clock monitor
`timescale 1ns/100ps
module lhcf_xtal_model (
    input  wire logic        sys_clk_i,  // bench clock, counts the start-up time
    input  wire logic        run_i,      // source powered and oscillating
    input  wire logic [15:0] startup_i,  // cycles before a clean signal shows
    output logic             present_o   // monitor sees a good clock
);
    logic [15:0] age_q;                  // cycles since the source was started
    // age restarts whenever the source stops, so a slow crystal shows up late
    always_ff @(posedge sys_clk_i) begin
        if (!run_i) begin
            age_q <= 16'h0000;
        end else if (age_q != 16'hFFFF) begin
            age_q <= age_q + 16'h0001;
        end
    end
    // presence only once stable; it drops at once when the source stops
    assign present_o = run_i && (age_q >= startup_i);
endmodule

// File: tb_limp_home_clock_fallback.sv
// self-checking bench for the limp-home clock fallback controller
`timescale 1ns/100ps
`include "lhcf_regs.svh"
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin n_errors++; \
    $display("unexpected %s expected %0h seen %0h", nm, ex, gt); end end
`define WAIT_UNTIL(c, b) begin k = 0; while (!(c) && k < (b)) begin step(1); k++; end \
    if (!(c)) begin n_errors++; $display("unexpected wait expected 1 seen 0"); \
    give_verdict(); end end
module tb_limp_home_clock_fallback;
    localparam int MID = int'(`LHCF_MID_COUNT);   // counter check point
    localparam int PER = int'(`LHCF_CHECK_EVERY); // spacing of later checks
    // clock, reset and design inputs
    logic sys_clk_i = 1'b0;
    logic reset_i, clk_en_i, por_i, pll_supply_i, special_mode_i;
    logic clock_monitor_on_i, forced_clock_monitor_on_i, fallback_disable_i;
    logic fallback_disable_we_i, clock_monitor_on_we_i, bus_clock_from_pll_i;
    logic module_clock_select_i, auto_bw_i, fallback_irq_enable_i, change_flag_clr_i;
    logic stop_exit_delay_i, stop_req_i, ext_reset_i, irq_pin_i, nonmaskable_irq_pin_i;
    logic key_wake_j_i, key_wake_h_i, can_wake_i;
    logic [5:0] wake;                   // one bit per stop wake source
    // design outputs and the crystal model's presence line
    logic ext_clk_present_i, fallback_active_flag_o, fallback_change_flag_o, fallback_irq_o;
    logic pll_on_a_o, bus_clock_from_pll_o, module_clock_select_o, base_system_clock_from_vco_min_o;
    logic modclk_from_pll_o, monitor_enable_o, clock_monitor_on_o, fallback_disable_o;
    logic internal_reset_o, monitor_reset_o, stopped_o, pll_relock_o;
    // crystal control and model bookkeeping
    logic        xtal_run;              // crystal oscillating
    logic [15:0] xtal_start;            // crystal start-up cycles
    logic [31:0] rnd;                   // xorshift state
    logic [1:0]  sel_q[$];              // pre-loss selects kept by the model
    logic [1:0]  sel;                   // selects expected after exit
    int          n_errors = 0;
    int          n_checks = 0;
    int          k;                     // cycles spent in the last wait
    int          t_loss;                // cycles from loss to fallback flag
    bit          relock_seen;           // relock pulse observed
    assign {ext_reset_i, can_wake_i, key_wake_h_i, key_wake_j_i} = wake[5:2];
    assign {nonmaskable_irq_pin_i, irq_pin_i} = wake[1:0];
    // free-running 40 MHz clock
    always #12.5 sys_clk_i = ~sys_clk_i;
    // catch the one-cycle relock pulse
    always @(posedge sys_clk_i) if (pll_relock_o === 1'b1) relock_seen <= 1'b1;
    lhcf_fallback lhcf_fallback_inst (.*);
    lhcf_xtal_model lhcf_xtal_model_inst (.sys_clk_i(sys_clk_i), .run_i(xtal_run),
        .startup_i(xtal_start), .present_o(ext_clk_present_i));
    // advance n edges, landing just after the last one
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    // one-cycle strobe on a control input
    task automatic strobe(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // reset, power-on pulse, then time the internal reset period
    task automatic power_up(input logic present);
        reset_i = 1'b1;
        por_i = 1'b1;
        xtal_run = present;
        xtal_start = 16'h0000;
        step(3);
        reset_i = 1'b0;
        step(1);
        `CHK("monitor bit", 1'b1, clock_monitor_on_o)
        `CHK("pll on", 1'b1, pll_on_a_o)
        `CHK("disable bit", 1'b0, fallback_disable_o)
        por_i = 1'b0;
        `WAIT_UNTIL(internal_reset_o === 1'b0, MID + 50)
        `CHK("reset period", 1'b1, (k >= MID - 4 && k <= MID + 8))
    endtask
    initial begin
        {reset_i, clk_en_i, por_i, pll_supply_i, special_mode_i} = 5'h1E;
        {clock_monitor_on_i, forced_clock_monitor_on_i, fallback_disable_i} = 3'h4;
        {fallback_disable_we_i, clock_monitor_on_we_i, change_flag_clr_i} = 3'h0;
        {bus_clock_from_pll_i, module_clock_select_i, auto_bw_i} = 3'h1;
        {fallback_irq_enable_i, stop_exit_delay_i, stop_req_i} = 3'h6;
        {wake, xtal_run, xtal_start, relock_seen} = '0;
        rnd = 32'hE7AC;
        // cold start with no crystal: leave reset in fallback
        power_up(1'b0);
        `CHK("active at start", 1'b1, fallback_active_flag_o)
        `CHK("change at start", 1'b1, fallback_change_flag_o)
        strobe(change_flag_clr_i);
        step(1);
        `CHK("change cleared", 1'b0, fallback_change_flag_o)
        xtal_start = 16'h0064;
        xtal_run = 1'b1;
        `WAIT_UNTIL(fallback_active_flag_o === 1'b0, PER + 50)
        `CHK("exit change", 1'b1, fallback_change_flag_o)
        `CHK("exit irq", 1'b1, fallback_irq_o)
        // warm start with the crystal running
        power_up(1'b1);
        `CHK("no fallback", 1'b0, fallback_active_flag_o)
        // clock loss in run with random pre-loss selects
        rnd = xs(rnd);
        {bus_clock_from_pll_i, module_clock_select_i} = rnd[1:0];
        sel_q.push_back(rnd[1:0]);
        step(3);
        strobe(change_flag_clr_i);
        relock_seen = 1'b0;
        xtal_run = 1'b0;
        `WAIT_UNTIL(fallback_active_flag_o === 1'b1, 10)
        t_loss = k;
        `CHK("pll forced", 1'b1, pll_on_a_o)
        `CHK("bus forced", 1'b1, bus_clock_from_pll_o)
        `CHK("module forced", 1'b0, module_clock_select_o)
        `CHK("vco min", 1'b1, base_system_clock_from_vco_min_o)
        `CHK("module clocks", 1'b1, modclk_from_pll_o)
        `CHK("loss irq", 1'b1, fallback_irq_o)
        clock_monitor_on_i = 1'b0;
        strobe(clock_monitor_on_we_i);
        `CHK("monitor held", 1'b1, monitor_enable_o)
        step(4199);
        xtal_run = 1'b1;
        `WAIT_UNTIL(fallback_active_flag_o === 1'b0, PER)
        k = k + 4204 + t_loss;
        `CHK("exit time", 1'b1, (k >= MID + PER - 6 && k <= MID + PER + 6))
        sel = sel_q.pop_front();
        `CHK("bus restored", sel[1], bus_clock_from_pll_o)
        `CHK("module restored", sel[0], module_clock_select_o)
        `CHK("monitor from bits", 1'b0, monitor_enable_o)
        `CHK("vco released", 1'b0, base_system_clock_from_vco_min_o)
        step(4);
        `CHK("relock", sel[1], relock_seen)
        // fallback disabled: a loss gives a monitor reset instead
        clock_monitor_on_i = 1'b1;
        strobe(clock_monitor_on_we_i);
        fallback_disable_i = 1'b1;
        strobe(fallback_disable_we_i);
        step(1);
        `CHK("disable stored", 1'b1, fallback_disable_o)
        xtal_run = 1'b0;
        `WAIT_UNTIL(monitor_reset_o === 1'b1, 10)
        `CHK("no fallback", 1'b0, fallback_active_flag_o)
        xtal_run = 1'b1;
        `WAIT_UNTIL(monitor_reset_o === 1'b0 && internal_reset_o === 1'b0, MID + PER)
        `CHK("left in run", 1'b0, fallback_active_flag_o)
        `CHK("disable reset", 1'b0, fallback_disable_o)
        `CHK("monitor reset", 1'b1, clock_monitor_on_o)
        strobe(fallback_disable_we_i);
        // stop with fallback and monitor off, one pass per wake source
        clock_monitor_on_i = 1'b0;
        strobe(clock_monitor_on_we_i);
        for (int i = 0; i < 6; i++) begin
            stop_exit_delay_i = (i == 0); // delay bit set on the first pass only
            step(1);
            strobe(stop_req_i);
            `WAIT_UNTIL(stopped_o === 1'b1, 10)
            `CHK("no monitor fail", 1'b0, monitor_reset_o)
            wake = 6'h01 << i;
            step(1);
            wake = 6'h00;
            `WAIT_UNTIL(stopped_o === 1'b0, MID + 50)
            if (i == 0) begin
                `CHK("stop delay", 1'b1, (k >= MID - 4 && k <= MID + 8))
            end else begin
                `CHK("fast exit", 1'b1, (k <= 8))
            end
        end
        // special mode without crystal: no fallback, reset is held
        special_mode_i = 1'b1;
        reset_i = 1'b1;
        por_i = 1'b1;
        xtal_run = 1'b0;
        step(3);
        reset_i = 1'b0;
        por_i = 1'b0;
        step(MID + 20);
        `CHK("special held", 1'b1, internal_reset_o)
        `CHK("special no fallback", 1'b0, fallback_active_flag_o)
        // grounded pll supply: static until the crystal shows up
        special_mode_i = 1'b0;
        pll_supply_i = 1'b0;
        reset_i = 1'b1;
        por_i = 1'b1;
        step(3);
        reset_i = 1'b0;
        por_i = 1'b0;
        step(MID + 20);
        `CHK("grounded held", 1'b1, internal_reset_o)
        `CHK("grounded pll off", 1'b0, pll_on_a_o)
        `CHK("grounded no fallback", 1'b0, fallback_active_flag_o)
        xtal_run = 1'b1;
        `WAIT_UNTIL(internal_reset_o === 1'b0, PER + 50)
        `CHK("grounded run", 1'b0, fallback_active_flag_o)
        give_verdict();
    end
endmodule
